//--- rtl/panel_cfg.svh
// constants for the panel column driver
// What this block does
// - ninety-six shift stages feed a 96-bit latch driving 96 panel outputs
// - width select high: three 32-stage chains; low: six 16-stage chains
// - chains advance one stage only on shift clock rising edge, else hold
// - direction high: shift right, take A lanes, drive B lanes
// - direction low: shift left, take B lanes, drive A lanes
// - all chains shift together in the one selected direction
// - right shift moves top stages up and shows last stages on B lanes
// - left shift moves bottom stages down and shows first stages on A lanes
// - clear input low forces every shift stage low
// - latch captures all stages on strobe falling edge, else holds
// - not floating and low blank asserted: all panel outputs low
// - not floating, low blank off, high blank on: all outputs high
// - float high puts every panel output in high impedance
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH
`define STAGES 96
`define WORD_W 32
`define FIFO_DEPTH 16
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DATA 8'h08
`define REG_COUNT 8'h0c
`define CTRL_CAPTURE 0
`define CTRL_RST 1'b0
`define STAT_OVERRUN 4
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define WIDE_MASK 6'h07
`define NARROW_MASK 6'h3f
`endif

//--- rtl/panel_pkg.sv
// types shared by the panel column driver
package panel_pkg;
  typedef struct packed {
    logic shift_clk;
    logic right;
    logic wide;
    logic latch_n;
    logic low_n;
    logic high_n;
    logic float_en;
    logic clear_n;
    logic [5:0] a;
    logic [5:0] b;
  } pin_t;

  typedef struct packed {
    logic [5:0] a_out;
    logic [5:0] a_oe;
    logic [5:0] b_out;
    logic [5:0] b_oe;
  } lane_t;

  typedef enum logic {
    cap_idle = 1'b0,
    cap_push = 1'b1
  } cap_state_t;
endpackage : panel_pkg

//--- rtl/word_fifo.sv
// synchronous word fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "panel_cfg.svh"

module word_fifo #(
  parameter int WIDTH = `WORD_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // level flags
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t n;
  logic push;
  logic pop;

  assign full = r.count == (AW + 1)'(DEPTH);
  assign empty = r.count == '0;
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = r.mem[r.rd];

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    n = r;
    if (push) begin
      n.mem[r.wr] = in_data;
      n.wr = r.wr + 1'b1;
    end
    if (pop) begin
      n.rd = r.rd + 1'b1;
    end
    n.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);
    if (!aresetn) begin
      n = '0;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end
endmodule : word_fifo
`default_nettype wire

//--- rtl/panel_column_driver.sv
// column shift chains, latch, panel outputs and AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "panel_cfg.svh"

module panel_column_driver
  import panel_pkg::*;
#(
  parameter int N = `STAGES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host control pins
  input wire logic shift_clk,
  input wire logic shift_right,
  input wire logic chain_width_select,
  input wire logic latch_strobe_n,
  input wire logic force_low_blank_n,
  input wire logic force_high_blank_n,
  input wire logic output_float,
  input wire logic chain_clear_n,
  // serial lanes, A side
  input wire logic [5:0] a_in,
  output logic [5:0] a_out,
  output logic [5:0] a_oe,
  // serial lanes, B side
  input wire logic [5:0] b_in,
  output logic [5:0] b_out,
  output logic [5:0] b_oe,
  // panel outputs
  output logic [N-1:0] panel_outputs,
  output logic [N-1:0] panel_oe
);
  localparam int WORDS = N / `WORD_W;
  localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;

  if (N < 12 || N % 6 != 0 || N % `WORD_W != 0) begin : g_bad_n
    $error("stage count must be a multiple of 6 and of 32");
  end

  typedef struct packed {
    pin_t s1;
    pin_t s2;
    logic clk_d;
    logic latch_d;
    logic [N-1:0] chain;
    logic [N-1:0] latched;
    logic [N-1:0] pout;
    logic [N-1:0] poe;
    lane_t lane;
    logic [31:0] shifts;
    logic capture_en;
    logic overrun;
    cap_state_t cap;
    logic [IW-1:0] idx;
    logic [N-1:0] buf_q;
    logic aw_hold;
    logic [`ADDR_W-1:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t r;
  state_t n;
  pin_t pins_now;
  logic clk_rise;
  logic latch_fall;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic ovr_set;
  logic ovr_clear;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_full;
  logic fifo_empty;
  logic [31:0] fifo_data;

  // inactive levels for the synchronisers at reset, except float, which is held high
  function automatic pin_t pin_idle();
    pin_t p;
    p = '0;
    p.latch_n = 1'b1;
    p.low_n = 1'b1;
    p.high_n = 1'b1;
    p.float_en = 1'b1;
    p.clear_n = 1'b1;
    return p;
  endfunction : pin_idle

  function automatic logic [5:0] lane_mask(input logic wide);
    return wide ? `WIDE_MASK : `NARROW_MASK;
  endfunction : lane_mask

  // stage i is bit i-1; chains interleave with stride 3 or 6
  function automatic logic [N-1:0] shift_step(
    input logic [N-1:0] s,
    input logic right,
    input logic wide,
    input logic [5:0] a,
    input logic [5:0] b
  );
    logic [N-1:0] t;
    if (right) begin
      t = wide ? {s[N-4:0], a[2:0]} : {s[N-7:0], a};
    end else begin
      t = wide ? {b[2:0], s[N-1:3]} : {b, s[N-1:6]};
    end
    return t;
  endfunction : shift_step

  function automatic logic [5:0] serial_out(
    input logic [N-1:0] s,
    input logic right,
    input logic wide
  );
    logic [5:0] t;
    if (right) begin
      t = wide ? {3'h0, s[N-1:N-3]} : s[N-1:N-6];
    end else begin
      t = wide ? {3'h0, s[2:0]} : s[5:0];
    end
    return t;
  endfunction : serial_out

  assign pins_now = '{
    shift_clk: shift_clk,
    right: shift_right,
    wide: chain_width_select,
    latch_n: latch_strobe_n,
    low_n: force_low_blank_n,
    high_n: force_high_blank_n,
    float_en: output_float,
    clear_n: chain_clear_n,
    a: a_in,
    b: b_in
  };

  // edges seen only past the second synchroniser stage
  assign clk_rise = r.s2.shift_clk & ~r.clk_d;
  assign latch_fall = ~r.s2.latch_n & r.latch_d;

  assign s_axi_awready = ~r.aw_hold & ~r.bvalid;
  assign s_axi_wready = ~r.w_hold & ~r.bvalid;
  assign s_axi_arready = ~r.rvalid;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign fifo_pop = ar_fire & (s_axi_araddr == `REG_DATA) & fifo_out_valid;

  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign a_out = r.lane.a_out;
  assign a_oe = r.lane.a_oe;
  assign b_out = r.lane.b_out;
  assign b_oe = r.lane.b_oe;
  assign panel_outputs = r.pout;
  assign panel_oe = r.poe;

  word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_frame_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(r.cap == cap_push),
    .in_ready(fifo_in_ready),
    .in_data(r.buf_q[{r.idx, 5'h0} +: `WORD_W]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  always_comb begin
    n = r;
    ovr_set = 1'b0;
    ovr_clear = 1'b0;
    n.s1 = pins_now;
    n.s2 = r.s1;
    n.clk_d = r.s2.shift_clk;
    n.latch_d = r.s2.latch_n;

    // shift chains
    if (!r.s2.clear_n) begin
      n.chain = '0;
      n.shifts = '0;
    end else if (clk_rise) begin
      // one direction for every chain
      n.chain = shift_step(r.chain, r.s2.right, r.s2.wide, r.s2.a, r.s2.b);
      n.shifts = r.shifts + 32'h1;
    end

    if (latch_fall) begin
      n.latched = r.chain;
    end

    // lane drivers follow direction and width
    n.lane = '0;
    if (r.s2.right) begin
      n.lane.b_oe = lane_mask(r.s2.wide);
      n.lane.b_out = serial_out(n.chain, 1'b1, r.s2.wide);
    end else begin
      n.lane.a_oe = lane_mask(r.s2.wide);
      n.lane.a_out = serial_out(n.chain, 1'b0, r.s2.wide);
    end

    // panel driver priority: float, low blank, high blank, data
    if (r.s2.float_en) begin
      n.poe = '0;
      n.pout = '0;
    end else if (!r.s2.low_n) begin
      n.poe = '1;
      n.pout = '0;
    end else if (!r.s2.high_n) begin
      n.poe = '1;
      n.pout = '1;
    end else begin
      n.poe = '1;
      n.pout = n.latched;
    end

    // frame capture into the fifo, stalled while it is full
    unique case (r.cap)
      cap_idle: begin
        if (latch_fall && r.capture_en) begin
          n.cap = cap_push;
          n.idx = '0;
          n.buf_q = r.chain;
        end
      end
      cap_push: begin
        if (latch_fall && r.capture_en) begin
          ovr_set = 1'b1;
        end
        if (fifo_in_ready) begin
          n.idx = r.idx + 1'b1;
          if (r.idx == IW'(WORDS - 1)) begin
            n.cap = cap_idle;
          end
        end
      end
    endcase

    // axi write path
    if (aw_fire) begin
      n.aw_hold = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      n.w_hold = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold && !r.bvalid) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (r.awaddr)
        `REG_CTRL: begin
          if (r.wstrb[0]) begin
            n.capture_en = r.wdata[`CTRL_CAPTURE];
          end
        end
        `REG_STATUS: begin
          ovr_clear = r.wstrb[0] & r.wdata[`STAT_OVERRUN];
        end
        `REG_DATA, `REG_COUNT: begin
        end
        default: begin
          n.bresp = `RESP_SLVERR;
        end
      endcase
    end

    // set beats clear
    if (ovr_clear) begin
      n.overrun = 1'b0;
    end
    if (ovr_set) begin
      n.overrun = 1'b1;
    end

    // axi read path
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (ar_fire) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      n.rdata = '0;
      case (s_axi_araddr)
        `REG_CTRL: begin
          n.rdata[`CTRL_CAPTURE] = r.capture_en;
        end
        `REG_STATUS: begin
          n.rdata[5:0] = {r.cap == cap_push, r.overrun, fifo_full, fifo_empty,
                          r.s2.wide, r.s2.right};
        end
        `REG_DATA: begin
          n.rdata = fifo_out_valid ? fifo_data : '0;
        end
        `REG_COUNT: begin
          n.rdata = r.shifts;
        end
        default: begin
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end

    if (!aresetn) begin
      n = '0;
      n.s1 = pin_idle();
      n.s2 = pin_idle();
      n.latch_d = 1'b1;
      n.capture_en = `CTRL_RST;
    end
  end

  always_ff @(posedge aclk) begin
    r <= n;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_clear;
    !r.s2.clear_n |=> r.chain == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("chain not cleared");

  property p_hold;
    r.s2.clear_n && !clk_rise |=> $stable(r.chain);
  endproperty
  a_hold: assert property (p_hold) else $error("chain moved without edge");

  property p_right_wide;
    clk_rise && r.s2.clear_n && r.s2.right && r.s2.wide |=>
      r.chain[N-1:N-3] == $past(r.chain[N-4:N-6]) && r.chain[2:0] == $past(r.s2.a[2:0]);
  endproperty
  a_right_wide: assert property (p_right_wide) else $error("bad right shift");

  property p_left_wide;
    clk_rise && r.s2.clear_n && !r.s2.right && r.s2.wide |=>
      r.chain[2:0] == $past(r.chain[5:3]) && r.chain[N-1:N-3] == $past(r.s2.b[2:0]);
  endproperty
  a_left_wide: assert property (p_left_wide) else $error("bad left shift");

  property p_right_narrow;
    clk_rise && r.s2.clear_n && r.s2.right && !r.s2.wide |=>
      r.chain[N-1:6] == $past(r.chain[N-7:0]) && r.chain[5:0] == $past(r.s2.a);
  endproperty
  a_right_narrow: assert property (p_right_narrow) else $error("bad six-lane shift");

  property p_left_narrow;
    clk_rise && r.s2.clear_n && !r.s2.right && !r.s2.wide |=>
      r.chain[N-7:0] == $past(r.chain[N-1:6]) && r.chain[N-1:N-6] == $past(r.s2.b);
  endproperty
  a_left_narrow: assert property (p_left_narrow) else $error("bad six-lane left");

  property p_b_drive;
    r.s2.right |=> a_oe == '0 && b_oe == lane_mask($past(r.s2.wide))
      && b_out[2:0] == ($past(r.s2.wide) ? r.chain[N-1:N-3] : r.chain[N-4:N-6]);
  endproperty
  a_b_drive: assert property (p_b_drive) else $error("B lanes wrong");

  property p_a_drive;
    !r.s2.right ##1 !r.s2.right |-> b_oe == '0 && a_oe == lane_mask($past(r.s2.wide))
      && a_out[2:0] == r.chain[2:0];
  endproperty
  a_a_drive: assert property (p_a_drive) else $error("A lanes wrong");

  property p_latch_take;
    latch_fall |=> r.latched == $past(r.chain);
  endproperty
  a_latch_take: assert property (p_latch_take) else $error("latch missed");

  property p_latch_hold;
    !latch_fall |=> $stable(r.latched);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

  property p_float;
    r.s2.float_en |=> panel_oe == '0;
  endproperty
  a_float: assert property (p_float) else $error("outputs not floating");

  property p_low;
    !r.s2.float_en && !r.s2.low_n |=> &panel_oe && panel_outputs == '0;
  endproperty
  a_low: assert property (p_low) else $error("low blank failed");

  property p_high;
    !r.s2.float_en && r.s2.low_n && !r.s2.high_n |=> &panel_oe && &panel_outputs;
  endproperty
  a_high: assert property (p_high) else $error("high blank failed");

  property p_data;
    !r.s2.float_en && r.s2.low_n && r.s2.high_n |=> &panel_oe && panel_outputs == r.latched;
  endproperty
  a_data: assert property (p_data) else $error("outputs differ from latch");

  c_right_wide: cover property (clk_rise && r.s2.right && r.s2.wide);
  c_left_narrow: cover property (clk_rise && !r.s2.right && !r.s2.wide);
  c_overrun: cover property (ovr_set);
  c_fifo_full: cover property (fifo_full && r.cap == cap_push);
endmodule : panel_column_driver
`default_nettype wire

//--- verification/pin_host.sv
// host-side pin driver model for the column driver
`timescale 1ns/1ps
`default_nettype none
module pin_host
  import panel_pkg::*;
(
  // clock
  input wire logic aclk,
  // pin levels toward the driver
  output pin_t pins
);
  pin_t p;
  logic tog = 1'b0;
  always @(posedge aclk) tog <= ~tog;
  // released lanes toggle instead of keeping their last value; unused lanes stay low
  always_comb begin
    pins = p;
    if (p.right) pins.b = {6{tog}} & (p.wide ? 6'h07 : 6'h3f);
    else pins.a = {6{tog}} & (p.wide ? 6'h07 : 6'h3f);
  end
  // idle levels: strobe, blanks, float and clear high, right, wide
  initial p = {8'h7f, 12'h000};
  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_n
  task automatic mode(input logic r, input logic w);
    p.right <= r;
    p.wide <= w;
    p.a <= 6'h00;
    p.b <= 6'h00;
    wait_n(3);
  endtask : mode
  // one shift clock period, equal low and high phases
  task automatic shift(input logic [5:0] d);
    if (p.right) p.a <= p.wide ? {3'h0, d[2:0]} : d;
    else p.b <= p.wide ? {3'h0, d[2:0]} : d;
    wait_n(3);
    p.shift_clk <= 1'b1;
    wait_n(3);
    p.shift_clk <= 1'b0;
  endtask : shift
  task automatic strobe();
    p.latch_n <= 1'b0;
    wait_n(3);
    p.latch_n <= 1'b1;
    wait_n(3);
  endtask : strobe
  task automatic outctl(input logic f, input logic l, input logic h);
    p.float_en <= f;
    p.low_n <= l;
    p.high_n <= h;
    wait_n(4);
  endtask : outctl
  task automatic clear();
    p.clear_n <= 1'b0;
    wait_n(3);
    p.clear_n <= 1'b1;
    wait_n(3);
  endtask : clear
endmodule : pin_host
`default_nettype wire

//--- verification/panel_column_driver_tb.sv
// self-checking bench for the panel column driver
`timescale 1ns/1ps
`default_nettype none
module panel_column_driver_tb
  import panel_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [5:0] ao, aoe, bo, boe, a_in, b_in;
  logic [95:0] po, poe;
  logic [95:0] s = '0;
  logic [95:0] lat = '0;
  pin_t pins;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int nsh = 0;
  always #12.5 aclk = ~aclk;
  // each lane wire resolved from both drivers
  assign a_in = (aoe & ao) | (~aoe & pins.a);
  assign b_in = (boe & bo) | (~boe & pins.b);
  pin_host host (.aclk(aclk), .pins(pins));
  panel_column_driver dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .shift_clk(pins.shift_clk), .shift_right(pins.right),
    .chain_width_select(pins.wide), .latch_strobe_n(pins.latch_n),
    .force_low_blank_n(pins.low_n), .force_high_blank_n(pins.high_n),
    .output_float(pins.float_en), .chain_clear_n(pins.clear_n),
    .a_in(a_in), .a_out(ao), .a_oe(aoe), .b_in(b_in), .b_out(bo), .b_oe(boe),
    .panel_outputs(po), .panel_oe(poe));
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    logic ta, tw, pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awa <= ad;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (pa | pw) begin
      @(negedge aclk);
      ta = pa & awr;
      tw = pw & wrd;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    do begin
      @(negedge aclk);
      ta = bv;
      rs = br;
      @(posedge aclk);
    end while (!ta);
    bry <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
    logic ta;
    ara <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arv & arr;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end while (!ta);
    do begin
      @(negedge aclk);
      ta = rv;
      d = rdat;
      rs = rr;
      @(posedge aclk);
    end while (!ta);
    rry <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic t_regs();
    logic [31:0] v;
    logic [1:0] rs;
    rd(8'h00, v, rs);
    chk(v, 32'h0);
    rd(8'h10, v, rs);
    chk(rs, 2'h2);
    wr(8'h13, 32'h1, rs);
    chk(rs, 2'h2);
    wr(8'h08, 32'h1, rs);
    chk(rs, 2'h0);
  endtask : t_regs
  task automatic t_shift(input logic r, input logic w);
    logic [5:0] d;
    logic [31:0] v;
    logic [1:0] rs;
    host.mode(r, w);
    for (int i = 0; i < 40; i++) begin
      d = 6'(i * 13 + 5 + r);
      host.shift(d);
      nsh++;
      if (r) s = w ? {s[92:0], d[2:0]} : {s[89:0], d};
      else s = w ? {d[2:0], s[95:3]} : {d, s[95:6]};
    end
    host.wait_n(3);
    chk(po, lat);
    if (r) begin
      chk(bo, w ? {3'h0, s[95:93]} : s[95:90]);
      chk(boe, w ? 6'h07 : 6'h3f);
      chk(aoe, 6'h00);
    end else begin
      chk(ao, w ? {3'h0, s[2:0]} : s[5:0]);
      chk(aoe, w ? 6'h07 : 6'h3f);
      chk(boe, 6'h00);
    end
    rd(8'h0c, v, rs);
    chk(v, nsh);
    rd(8'h04, v, rs);
    chk(v[1:0], {w, r});
    host.strobe();
    lat = s;
    chk(po, lat);
    chk(poe, '1);
  endtask : t_shift
  task automatic t_blank();
    host.outctl(1'b0, 1'b0, 1'b0);
    chk(po, '0);
    chk(poe, '1);
    host.outctl(1'b0, 1'b1, 1'b0);
    chk(po, '1);
    host.outctl(1'b1, 1'b0, 1'b0);
    chk(poe, '0);
    host.outctl(1'b1, 1'b1, 1'b1);
    chk(poe, '0);
    host.outctl(1'b0, 1'b1, 1'b1);
    chk(po, lat);
  endtask : t_blank
  task automatic t_capture();
    logic [31:0] v;
    logic [1:0] rs;
    wr(8'h00, 32'h1, rs);
    repeat (7) host.strobe();
    rd(8'h04, v, rs);
    chk(v[3], 1'b1);
    chk(v[4], 1'b1);
    for (int k = 0; k < 3; k++) begin
      rd(8'h08, v, rs);
      chk(v, lat[k*32 +: 32]);
    end
    for (int k = 0; k < 20; k++) begin
      rd(8'h04, v, rs);
      if (v[2]) break;
      rd(8'h08, v, rs);
    end
    chk(v[2], 1'b1);
    rd(8'h08, v, rs);
    chk(v, 32'h0);
    wr(8'h04, 32'h10, rs);
    rd(8'h04, v, rs);
    chk(v[4], 1'b0);
    wr(8'h00, 32'h0, rs);
  endtask : t_capture
  task automatic t_clear();
    logic [31:0] v;
    logic [1:0] rs;
    host.clear();
    rd(8'h0c, v, rs);
    chk(v, 32'h0);
    host.strobe();
    chk(po, '0);
  endtask : t_clear
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    host.wait_n(3);
    host.outctl(1'b0, 1'b1, 1'b1);
    t_regs();
    t_shift(1'b1, 1'b1);
    t_shift(1'b0, 1'b0);
    t_shift(1'b1, 1'b0);
    t_shift(1'b0, 1'b1);
    t_blank();
    t_capture();
    t_clear();
    summarize();
  end
endmodule : panel_column_driver_tb
`default_nettype wire
